// File: src/mrpa_regs.svh
// Constants for the move, reverse and parallel-add datapath slice
`ifndef MRPA_REGS_SVH
`define MRPA_REGS_SVH
`define MRPA_WORD_W      32
`define MRPA_HALF_W      16
`define MRPA_BYTE_W      8
`define MRPA_LANE_FLAGS  4
`define MRPA_PC_ALIGN_BIT 0
`define MRPA_SIGN_BIT    31
`define MRPA_NUM_REGS    16
`define MRPA_REG_IDX_W   4
`define MRPA_SP_IDX      4'hd
`define MRPA_PC_IDX      4'hf
`define MRPA_FLAGS_RST   4'h0
`define MRPA_WORD_RST    32'h0000_0000
`endif

// File: src/mrpa_pkg.sv
// Types for the move, reverse and parallel-add datapath slice
package mrpa_pkg;
   typedef enum logic [3:0] {
      OP_NONE,
      OP_COPY,
      OP_INVERT,
      OP_LOAD_UPPER,
      OP_BSWAP_WORD,
      OP_BSWAP_HALVES,
      OP_BSWAP_LOW_SEXT,
      OP_BIT_REVERSE,
      OP_SADD_HALF,
      OP_SADD_BYTE
   } op_t;
endpackage : mrpa_pkg

// File: src/lane_adder_if.sv
// Carrier between the main datapath and the signed lane adder
`timescale 1ns/1ps
interface lane_adder_if;
   logic [31:0] src_a;
   logic [31:0] src_b;
   logic        byte_mode;
   logic [31:0] sum;
   logic [3:0]  nonneg;
   modport requester (output src_a, output src_b, output byte_mode, input sum, input nonneg);
   modport adder     (input src_a, input src_b, input byte_mode, output sum, output nonneg);
endinterface : lane_adder_if

// File: src/signed_lane_adder.sv
// Combinational signed dual-halfword or quad-byte lane adder
`timescale 1ns/1ps
`include "mrpa_regs.svh"
module signed_lane_adder (
   lane_adder_if.adder port_io
);
   localparam int BL = `MRPA_BYTE_W;
   localparam int HL = `MRPA_HALF_W;
   logic [BL:0]  byte_sum [4];
   logic [HL:0]  half_sum [2];
   logic [31:0]  byte_res;
   logic [31:0]  half_res;
   logic [3:0]   byte_ge;
   logic [3:0]   half_ge;

   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_byte
         // Nine bits keep the full signed sum so its sign is true even when the lane wraps
         assign byte_sum[k] = {port_io.src_a[k*BL+BL-1], port_io.src_a[k*BL +: BL]}
                            + {port_io.src_b[k*BL+BL-1], port_io.src_b[k*BL +: BL]};
         assign byte_res[k*BL +: BL] = byte_sum[k][BL-1:0];
         assign byte_ge[k] = ~byte_sum[k][BL];
      end
      for (k = 0; k < 2; k++) begin : g_half
         assign half_sum[k] = {port_io.src_a[k*HL+HL-1], port_io.src_a[k*HL +: HL]}
                            + {port_io.src_b[k*HL+HL-1], port_io.src_b[k*HL +: HL]};
         assign half_res[k*HL +: HL] = half_sum[k][HL-1:0];
         assign half_ge[2*k]   = ~half_sum[k][HL];
         assign half_ge[2*k+1] = ~half_sum[k][HL];
      end
   endgenerate

   assign port_io.sum    = port_io.byte_mode ? byte_res : half_res;
   assign port_io.nonneg = port_io.byte_mode ? byte_ge : half_ge;
endmodule : signed_lane_adder

// File: src/move_reverse_parallel_add.sv
// Move, reverse and signed parallel-add execution slice
`timescale 1ns/1ps
`include "mrpa_regs.svh"
module move_reverse_parallel_add #(
   parameter int WORD_W = `MRPA_WORD_W
) (
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_n_in,
   input  wire logic                          issue_valid_in,
   input  mrpa_pkg::op_t                      op_in,
   input  wire logic                          cond_pass_in,
   input  wire logic                          set_flags_in,
   input  wire logic [`MRPA_REG_IDX_W-1:0]    dest_idx_in,
   input  wire logic                          dest_present_in,
   input  wire logic [`MRPA_REG_IDX_W-1:0]    first_src_idx_in,
   input  wire logic [WORD_W-1:0]             first_src_val_in,
   input  wire logic [WORD_W-1:0]             second_src_val_in,
   input  wire logic [WORD_W-1:0]             flexible_second_operand_in,
   input  wire logic                          shifter_carry_valid_in,
   input  wire logic                          shifter_carry_in,
   input  wire logic [WORD_W-1:0]             dest_old_val_in,
   input  wire logic [`MRPA_HALF_W-1:0]       immediate_halfword_in,
   input  wire logic                          flag_n_in,
   input  wire logic                          flag_z_in,
   input  wire logic                          flag_c_in,
   input  wire logic                          flag_v_in,
   input  wire logic [`MRPA_LANE_FLAGS-1:0]   lane_nonneg_flags_in,
   output logic                               dest_we_out,
   output logic [`MRPA_REG_IDX_W-1:0]         dest_idx_out,
   output logic [WORD_W-1:0]                  dest_val_out,
   output logic                               branch_out,
   output logic [WORD_W-1:0]                  branch_target_out,
   output logic                               flags_we_out,
   output logic                               flag_n_out,
   output logic                               flag_z_out,
   output logic                               flag_c_out,
   output logic                               flag_v_out,
   output logic                               lane_flags_we_out,
   output logic [`MRPA_LANE_FLAGS-1:0]        lane_nonneg_flags_out,
   output logic                               illegal_use_out
);
   // The lane adder and the byte layout are built for a 32-bit word only
   if (WORD_W != `MRPA_WORD_W) begin : g_width_check
      $error("WORD_W must be 32");
   end

   lane_adder_if lane_bus ();
   signed_lane_adder u_adder (.port_io(lane_bus));

   // Decode
   wire logic go          = issue_valid_in & cond_pass_in;
   wire logic is_copy     = (op_in == mrpa_pkg::OP_COPY);
   wire logic is_invert   = (op_in == mrpa_pkg::OP_INVERT);
   wire logic is_upper    = (op_in == mrpa_pkg::OP_LOAD_UPPER);
   wire logic is_rev      = (op_in == mrpa_pkg::OP_BSWAP_WORD) |
                            (op_in == mrpa_pkg::OP_BSWAP_HALVES) |
                            (op_in == mrpa_pkg::OP_BSWAP_LOW_SEXT) |
                            (op_in == mrpa_pkg::OP_BIT_REVERSE);
   wire logic is_sadd     = (op_in == mrpa_pkg::OP_SADD_HALF) |
                            (op_in == mrpa_pkg::OP_SADD_BYTE);
   wire logic move_like   = is_copy | is_invert;
   wire logic [`MRPA_REG_IDX_W-1:0] dest_sel =
      (is_sadd & ~dest_present_in) ? first_src_idx_in : dest_idx_in;
   wire logic dest_special = (dest_sel == `MRPA_SP_IDX) | (dest_sel == `MRPA_PC_IDX);
   wire logic src_special  = (first_src_idx_in == `MRPA_SP_IDX) |
                             (first_src_idx_in == `MRPA_PC_IDX);
   wire logic dest_is_pc   = (dest_sel == `MRPA_PC_IDX);

   // Misuse by the issuing side is flagged rather than silently executed oddly
   wire logic bad_copy  = is_copy & (dest_special | src_special) & set_flags_in;
   wire logic bad_inv   = is_invert & (dest_special | src_special);
   wire logic bad_upper = is_upper & dest_special;
   wire logic bad_other = (is_rev | is_sadd) & (dest_special | src_special);
   wire logic illegal   = bad_copy | bad_inv | bad_upper | bad_other;

   // Results
   wire logic [WORD_W-1:0] src = first_src_val_in;
   wire logic [WORD_W-1:0] move_res =
      is_invert ? ~flexible_second_operand_in : flexible_second_operand_in;
   wire logic [WORD_W-1:0] upper_res =
      {immediate_halfword_in, dest_old_val_in[`MRPA_HALF_W-1:0]};
   wire logic [WORD_W-1:0] bswap_word =
      {src[7:0], src[15:8], src[23:16], src[31:24]};
   wire logic [WORD_W-1:0] bswap_halves =
      {src[23:16], src[31:24], src[7:0], src[15:8]};
   wire logic [WORD_W-1:0] bswap_sext =
      {{`MRPA_HALF_W{src[7]}}, src[7:0], src[15:8]};
   logic [WORD_W-1:0] bit_rev;
   genvar i;
   generate
      for (i = 0; i < WORD_W; i++) begin : g_bit_reverse_word_op
         assign bit_rev[i] = src[WORD_W-1-i];
      end
   endgenerate

   assign lane_bus.src_a     = first_src_val_in;
   assign lane_bus.src_b     = second_src_val_in;
   assign lane_bus.byte_mode = (op_in == mrpa_pkg::OP_SADD_BYTE);

   logic [WORD_W-1:0] result;
   always_comb begin
      unique case (op_in)
         mrpa_pkg::OP_COPY, mrpa_pkg::OP_INVERT: result = move_res;
         mrpa_pkg::OP_LOAD_UPPER:     result = upper_res;
         mrpa_pkg::OP_BSWAP_WORD:     result = bswap_word;
         mrpa_pkg::OP_BSWAP_HALVES:   result = bswap_halves;
         mrpa_pkg::OP_BSWAP_LOW_SEXT: result = bswap_sext;
         mrpa_pkg::OP_BIT_REVERSE:    result = bit_rev;
         mrpa_pkg::OP_SADD_HALF, mrpa_pkg::OP_SADD_BYTE: result = lane_bus.sum;
         default:                     result = `MRPA_WORD_RST;
      endcase
   end

   wire logic [WORD_W-1:0] pc_target =
      {move_res[WORD_W-1:1], 1'b0};
   wire logic take_branch = go & is_copy & dest_is_pc & ~illegal;
   wire logic write_reg   = go & (move_like | is_upper | is_rev | is_sadd) & ~illegal
                            & ~take_branch;
   // Flags only for flag-setting copy/invert; reversals and upper load never touch them
   wire logic upd_flags   = go & move_like & set_flags_in & ~illegal;
   wire logic upd_lanes   = go & is_sadd & ~illegal;
   wire logic res_neg     = move_res[`MRPA_SIGN_BIT];
   wire logic res_zero    = (move_res == `MRPA_WORD_RST);
   wire logic carry_nxt   = shifter_carry_valid_in ? shifter_carry_in : flag_c_in;

   // Registered outputs: one cycle after issue
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dest_we_out           <= 1'b0;
         dest_idx_out          <= '0;
         dest_val_out          <= `MRPA_WORD_RST;
         branch_out            <= 1'b0;
         branch_target_out     <= `MRPA_WORD_RST;
         illegal_use_out       <= 1'b0;
      end else begin
         dest_we_out           <= write_reg;
         dest_idx_out          <= dest_sel;
         dest_val_out          <= take_branch ? pc_target : result;
         branch_out            <= take_branch;
         branch_target_out     <= pc_target;
         illegal_use_out       <= issue_valid_in & illegal;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_we_out          <= 1'b0;
         flag_n_out            <= 1'b0;
         flag_z_out            <= 1'b0;
         flag_c_out            <= 1'b0;
         flag_v_out            <= 1'b0;
         lane_flags_we_out     <= 1'b0;
         lane_nonneg_flags_out <= `MRPA_FLAGS_RST;
      end else begin
         flags_we_out          <= upd_flags;
         flag_n_out            <= upd_flags ? res_neg : flag_n_in;
         flag_z_out            <= upd_flags ? res_zero : flag_z_in;
         flag_c_out            <= upd_flags ? carry_nxt : flag_c_in;
         flag_v_out            <= flag_v_in;
         lane_flags_we_out     <= upd_lanes;
         lane_nonneg_flags_out <= upd_lanes ? lane_bus.nonneg
                                            : lane_nonneg_flags_in;
      end
   end
endmodule : move_reverse_parallel_add

// File: testbench/mrpa_properties.sv
// Port-level assertions for the move, reverse and parallel-add slice
`timescale 1ns/1ps
module mrpa_properties (
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic        issue_valid_in,
   input mrpa_pkg::op_t    op_in,
   input wire logic        cond_pass_in,
   input wire logic        set_flags_in,
   input wire logic [3:0]  dest_idx_in,
   input wire logic [3:0]  first_src_idx_in,
   input wire logic [31:0] first_src_val_in,
   input wire logic [31:0] second_src_val_in,
   input wire logic [31:0] flexible_second_operand_in,
   input wire logic [31:0] dest_old_val_in,
   input wire logic [15:0] immediate_halfword_in,
   input wire logic        flag_v_in,
   input wire logic        dest_we_out,
   input wire logic [31:0] dest_val_out,
   input wire logic        branch_out,
   input wire logic [31:0] branch_target_out,
   input wire logic        flags_we_out,
   input wire logic        flag_n_out,
   input wire logic        flag_z_out,
   input wire logic        flag_v_out,
   input wire logic        lane_flags_we_out,
   input wire logic        illegal_use_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   wire go = issue_valid_in && cond_pass_in;
   wire spc = dest_idx_in inside {4'hd, 4'hf} || first_src_idx_in inside {4'hd, 4'hf};
   wire cp = go && op_in == mrpa_pkg::OP_COPY;
   wire rvs = op_in inside {mrpa_pkg::OP_BSWAP_WORD, mrpa_pkg::OP_BSWAP_HALVES,
                            mrpa_pkg::OP_BSWAP_LOW_SEXT, mrpa_pkg::OP_BIT_REVERSE};
   wire [31:0] swp = {<<8{first_src_val_in}};
   wire [31:0] mir = {<<{first_src_val_in}};
   wire [31:0] sh = {first_src_val_in[31:16] + second_src_val_in[31:16],
                     first_src_val_in[15:0] + second_src_val_in[15:0]};

   copy_to_pc_a: assert property (cp && dest_idx_in == 4'hf && !set_flags_in |=> branch_out
      && !dest_we_out && branch_target_out == ($past(flexible_second_operand_in) & 32'hffff_fffe))
      else $error("copy to counter gave a wrong branch");
   copy_flags_a: assert property (cp && set_flags_in && !spc |=> flags_we_out
      && flag_n_out == dest_val_out[31] && flag_z_out == (dest_val_out == 32'h0)
      && flag_v_out == $past(flag_v_in)) else $error("copy flags wrong");
   upper_half_a: assert property (go && !spc && op_in == mrpa_pkg::OP_LOAD_UPPER |=> dest_we_out
      && !flags_we_out && dest_val_out == {$past(immediate_halfword_in), $past(dest_old_val_in[15:0])})
      else $error("upper half load wrong");
   word_swap_a: assert property (go && !spc && op_in == mrpa_pkg::OP_BSWAP_WORD
      |=> dest_we_out && dest_val_out == $past(swp)) else $error("word byte swap wrong");
   bit_mirror_a: assert property (go && !spc && op_in == mrpa_pkg::OP_BIT_REVERSE
      |=> dest_val_out == $past(mir)) else $error("bit mirror wrong");
   reverse_flags_a: assert property (go && rvs |=> !flags_we_out && !lane_flags_we_out)
      else $error("reversal touched flags");
   half_lanes_a: assert property (go && !spc && op_in == mrpa_pkg::OP_SADD_HALF
      |=> lane_flags_we_out && dest_val_out == $past(sh)) else $error("halfword lane sum wrong");
   cond_fail_a: assert property (issue_valid_in && !cond_pass_in |=>
      !(dest_we_out || branch_out || flags_we_out || lane_flags_we_out)) else $error("failed op wrote");
   misuse_block_a: assert property (go && rvs && first_src_idx_in == 4'hd
      |=> illegal_use_out && !dest_we_out) else $error("stack operand not refused");
   cover property (cp && dest_idx_in == 4'hf);
   cover property (go && op_in == mrpa_pkg::OP_SADD_BYTE);
   cover property (issue_valid_in && !cond_pass_in);
endmodule : mrpa_properties

// File: testbench/issue_legality.sv
// Decoder-side model of which special-register uses an instruction source may issue
`timescale 1ns/1ps
module issue_legality (
   input mrpa_pkg::op_t   op_in,
   input wire logic       set_flags_in,
   input wire logic [3:0] dest_idx_in,
   input wire logic [3:0] first_src_idx_in,
   output logic           legal_out
);
   wire sd = dest_idx_in inside {4'hd, 4'hf};
   wire sf = first_src_idx_in inside {4'hd, 4'hf};
   // Only a plain copy may name them, and an upper load as first source; the bench sends illegal forms on purpose
   assign legal_out = (op_in == mrpa_pkg::OP_COPY) ? !(set_flags_in && (sd || sf)) :
                      (op_in == mrpa_pkg::OP_LOAD_UPPER) ? !sd :
                      !(sd || sf);
endmodule : issue_legality

// File: testbench/test_move_reverse_parallel_add.sv
// Self-checking bench for the move, reverse and parallel-add slice
`timescale 1ns/1ps
module test_move_reverse_parallel_add;
   logic clk_sys_in = 1'b0, rst_n_in = 1'b0, issue_valid_in = 1'b0, cond_pass_in = 1'b0;
   logic set_flags_in = 1'b0, dest_present_in = 1'b1, shifter_carry_valid_in = 1'b0;
   logic shifter_carry_in = 1'b0, flag_n_in = 1'b0, flag_z_in = 1'b0, flag_c_in = 1'b0;
   logic flag_v_in = 1'b0, legal_out, dest_we_out, branch_out, flags_we_out, flag_n_out;
   logic flag_z_out, flag_c_out, flag_v_out, lane_flags_we_out, illegal_use_out;
   logic [3:0]  dest_idx_in = 4'h0, first_src_idx_in = 4'h0, lane_nonneg_flags_in = 4'h0;
   logic [3:0]  dest_idx_out, lane_nonneg_flags_out;
   logic [15:0] immediate_halfword_in = 16'h0;
   logic [31:0] first_src_val_in = 32'h0, second_src_val_in = 32'h0, dest_old_val_in = 32'h0;
   logic [31:0] flexible_second_operand_in = 32'h0, dest_val_out, branch_target_out;
   mrpa_pkg::op_t op_in = mrpa_pkg::OP_NONE;
   int fails = 0;
   int total_checks = 0;

   move_reverse_parallel_add DUT (.*);
   issue_legality decoder (.*);

   initial forever #2 clk_sys_in = ~clk_sys_in;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   // One issue; operands also feed the V, C and lane flag inputs and the shifter carry inputs so those vary too
   task automatic run(input mrpa_pkg::op_t op, input logic [3:0] d, input logic [3:0] f,
                      input logic c, input logic s, input logic [31:0] av, input logic [31:0] bv);
      @(posedge clk_sys_in);
      op_in <= op;
      dest_idx_in <= d;
      first_src_idx_in <= f;
      cond_pass_in <= c;
      set_flags_in <= s;
      first_src_val_in <= av;
      dest_old_val_in <= av;
      flag_v_in <= av[0];
      flag_c_in <= av[1];
      lane_nonneg_flags_in <= av[7:4];
      second_src_val_in <= bv;
      flexible_second_operand_in <= bv;
      immediate_halfword_in <= bv[15:0];
      shifter_carry_in <= bv[31];
      shifter_carry_valid_in <= bv[30];
      issue_valid_in <= 1'b1;
      @(posedge clk_sys_in);
      issue_valid_in <= 1'b0;
      #1;
      chk({31'h0, illegal_use_out}, {31'h0, ~legal_out});
      if (!legal_out)
         chk({30'h0, dest_we_out, branch_out}, 32'h0);
   endtask : run

   task automatic t_move;
      logic [31:0] v[4] = '{32'h0, 32'hffff_ffff, 32'h8000_0001, 32'h4000_0000};
      logic [31:0] r;
      for (int i = 0; i < 4; i++) begin
         run(i[0] ? mrpa_pkg::OP_INVERT : mrpa_pkg::OP_COPY, 4'h2, 4'h0, 1'b1, 1'b1, 32'(i), v[i]);
         r = i[0] ? ~v[i] : v[i];
         chk(dest_val_out, r);
         chk({dest_we_out, flags_we_out, flag_n_out, flag_z_out}, {2'b11, r[31], r == 32'h0});
         chk({flag_c_out, flag_v_out}, {v[i][30] ? v[i][31] : i[1], i[0]});
      end
      $display("move test done");
   endtask : t_move

   task automatic t_pc;
      run(mrpa_pkg::OP_COPY, 4'hf, 4'h0, 1'b1, 1'b0, 32'h0, 32'h0000_1235);
      chk({30'h0, branch_out, dest_we_out}, 32'h0000_0002);
      chk(branch_target_out, 32'h0000_1234);
      chk(dest_val_out, 32'h0000_1234);
      run(mrpa_pkg::OP_COPY, 4'h3, 4'hd, 1'b1, 1'b0, 32'h0, 32'h0000_0077);
      chk({31'h0, dest_we_out}, 32'h0000_0001);
      chk(dest_val_out, 32'h0000_0077);
      run(mrpa_pkg::OP_COPY, 4'hf, 4'h0, 1'b1, 1'b1, 32'h0, 32'h0000_1235);
      run(mrpa_pkg::OP_COPY, 4'hf, 4'h0, 1'b0, 1'b0, 32'h0, 32'h0000_1235);
      chk({31'h0, branch_out}, 32'h0);
      $display("counter test done");
   endtask : t_pc

   task automatic t_upper;
      run(mrpa_pkg::OP_LOAD_UPPER, 4'h3, 4'h0, 1'b1, 1'b1, 32'h1234_5678, 32'h0000_ffff);
      chk(dest_val_out, 32'hffff_5678);
      chk({dest_we_out, flags_we_out, lane_flags_we_out}, 3'b100);
      run(mrpa_pkg::OP_LOAD_UPPER, 4'hf, 4'h0, 1'b1, 1'b0, 32'h0, 32'h0000_0001);
      $display("upper half test done");
   endtask : t_upper

   task automatic t_rev;
      mrpa_pkg::op_t o[4] = '{mrpa_pkg::OP_BSWAP_WORD, mrpa_pkg::OP_BSWAP_HALVES,
                              mrpa_pkg::OP_BSWAP_LOW_SEXT, mrpa_pkg::OP_BIT_REVERSE};
      logic [31:0] e[4] = '{32'hf780_3412, 32'h3412_f780, 32'hffff_f780, 32'hef01_2c48};
      for (int i = 0; i < 4; i++) begin
         run(o[i], 4'h3, 4'h7, 1'b1, 1'b0, 32'h1234_80f7, 32'h0);
         chk(dest_val_out, e[i]);
         chk({dest_we_out, flags_we_out, lane_flags_we_out}, 3'b100);
         chk({lane_nonneg_flags_out, flag_n_out, flag_c_out, flag_v_out}, 7'h7b);
      end
      run(mrpa_pkg::OP_BSWAP_WORD, 4'h3, 4'hd, 1'b1, 1'b0, 32'h1234_80f7, 32'h0);
      $display("reverse test done");
   endtask : t_rev

   task automatic t_add;
      run(mrpa_pkg::OP_SADD_HALF, 4'h4, 4'h5, 1'b1, 1'b0, 32'h7fff_8000, 32'h0001_ffff);
      chk(dest_val_out, 32'h8000_7fff);
      chk({lane_flags_we_out, lane_nonneg_flags_out, dest_idx_out}, 9'h1_c4);
      run(mrpa_pkg::OP_SADD_BYTE, 4'h4, 4'h5, 1'b1, 1'b0, 32'h7f80_01ff, 32'h0180_ff01);
      chk(dest_val_out, 32'h8000_0000);
      chk({lane_flags_we_out, lane_nonneg_flags_out, flags_we_out}, 6'b1_1011_0);
      @(posedge clk_sys_in);
      dest_present_in <= 1'b0;
      run(mrpa_pkg::OP_SADD_BYTE, 4'h4, 4'h5, 1'b1, 1'b0, 32'h0000_0001, 32'h0000_0001);
      chk({dest_we_out, dest_idx_out}, 5'h15);
      @(posedge clk_sys_in);
      dest_present_in <= 1'b1;
      run(mrpa_pkg::OP_SADD_HALF, 4'h4, 4'h5, 1'b0, 1'b0, 32'h7fff_8000, 32'h0001_ffff);
      chk({dest_we_out, lane_flags_we_out, flags_we_out}, 3'b000);
      $display("lane add test done");
   endtask : t_add

   initial begin
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_move();
      t_pc();
      t_upper();
      t_rev();
      t_add();
      results();
   end
endmodule : test_move_reverse_parallel_add

bind move_reverse_parallel_add mrpa_properties props (.*);
